// ==== rtl/vtam_monitor.sv ====
// Valve travel history, pressure alerts, alert record and status enables.
// Assumes all measurement inputs come from logic on pclk; APB slave.
// ==========================================
// Overview of operation
// - Reversal counts as cycle only after travel leaves cycle deadband.
// - Travel accumulates only after leaving accumulator deadband around its reference.
// - Accumulator holds total travel since clear; writing zero clears it.
// - Enabled accumulator alert sets when value exceeds point; enable off by default.
// - Accumulator alert stays set until rewritten below the point.
// - Partial stroke test stops at pressure limit: minimum venting, maximum filling.
// - Enabled deviation alert sets after exceeding point longer than time; default on.
// - Deviation alert drops once difference is back under point, no deadband.
// - Deviation point reloads 2 psi when setup or auto calibration completes; only setup_done reloads it here.
// - Deviation time defaults to 30 seconds.
// - Alert recordable only if its own and its group enable are set.
// - New active enabled alert stores all active enabled alerts.
// - Groups fixed: valve six, failure eight, miscellaneous auxiliary input.
// - Failure and valve groups default on, miscellaneous off.
// - Each record entry carries date and 24-hour time from clock.
// - Has-entries flag enabled by default; full flag disabled by default.
// - Clear-all performed only when no enabled-group alert is active.
// - Status enables default: time invalid on, cal/autocal/diag off, data on.
// - Pressure control indication on by default, multi-drop off.
// - Integrator saturated high and low enables default on.
// - Integrator output clamped to limit, zero to 100 % drive.
// - Integral held inside dead zone around setpoint, 0 to 2 %, default 0.25 %.
// - Cycle count alert sets above point, clears on rewrite below point.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`default_nettype none
module vtam_monitor #(
  parameter int TICK_CYCLES = vtam_pkg::SECOND_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] travel,
  input wire logic [15:0] setpoint,
  input wire logic [15:0] press_target,
  input wire logic [15:0] press_actual,
  input wire logic partial_stroke_test_active,
  input wire logic partial_stroke_test_vent,
  input wire logic setup_done,
  input wire logic [15:0] integ_in,
  input wire vtam_pkg::vtam_alerts_s alerts_in,
  input wire vtam_pkg::vtam_rtc_s rtc_now,
  input wire logic [8:0] status_in,
  output logic partial_stroke_test_stop,
  output logic dev_alert,
  output logic acc_alert,
  output logic cyc_alert,
  output logic [15:0] integ_out,
  output logic integ_hold,
  output logic rec_has_entries,
  output logic rec_full,
  output logic [8:0] status_out
);
  // ==========================================
  // Helpers
  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  logic wr_en;
  logic acc_en_reg, cyc_en_reg, dev_en_reg, has_en_reg, full_en_reg;
  logic [2:0] grp_en_reg;
  logic [8:0] stat_en_reg;
  logic [31:0] acc_reg, acc_pt_reg, cyc_reg, cyc_pt_reg;
  logic [15:0] cyc_db_reg, acc_db_reg, cyc_ref_reg, acc_ref_reg;
  logic [15:0] dev_pt_reg, dev_time_reg, dev_cnt_reg, pst_lim_reg, integ_lim_reg, dz_reg;
  logic [14:0] rep_en_reg, elig, elig_prev_reg;
  logic [1:0] rec_sel_reg;
  logic [2:0] rec_cnt_reg;
  logic [14:0] rec_alerts_reg [vtam_pkg::REC_DEPTH];
  vtam_pkg::vtam_rtc_s rec_stamp_reg [vtam_pkg::REC_DEPTH];
  vtam_pkg::vtam_dir_e dir_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic wr_acc, wr_cyc, rec_trig, rec_clr, dev_over;
  logic [15:0] acc_step;
  logic [32:0] acc_sum;
  logic cyc_up, cyc_dn;

  assign wr_en = psel && penable && pwrite && pready;
  assign wr_acc = wr_en && hit(paddr, vtam_pkg::OFF_ACC);
  assign wr_cyc = wr_en && hit(paddr, vtam_pkg::OFF_CYC);

  // ==========================================
  // APB slave, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr[1:0] != 2'h0 || paddr > vtam_pkg::OFF_REC_CLEAR);
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          vtam_pkg::OFF_CTRL: prdata <= {7'h00, stat_en_reg, 5'h00, grp_en_reg, 3'h0,
            full_en_reg, has_en_reg, dev_en_reg, cyc_en_reg, acc_en_reg};
          vtam_pkg::OFF_ACC: prdata <= acc_reg;
          vtam_pkg::OFF_ACC_PT: prdata <= acc_pt_reg;
          vtam_pkg::OFF_CYC: prdata <= cyc_reg;
          vtam_pkg::OFF_CYC_PT: prdata <= cyc_pt_reg;
          vtam_pkg::OFF_DB: prdata <= {acc_db_reg, cyc_db_reg};
          vtam_pkg::OFF_DEV_PT: prdata <= {16'h0000, dev_pt_reg};
          vtam_pkg::OFF_DEV_TIME: prdata <= {16'h0000, dev_time_reg};
          vtam_pkg::OFF_PST_LIM: prdata <= {16'h0000, pst_lim_reg};
          vtam_pkg::OFF_INTEG: prdata <= {dz_reg, integ_lim_reg};
          vtam_pkg::OFF_REP_EN: prdata <= {17'h00000, rep_en_reg};
          vtam_pkg::OFF_STATUS: prdata <= {21'h000000, rec_cnt_reg, 2'h0, rec_full,
            rec_has_entries, partial_stroke_test_stop, dev_alert, cyc_alert, acc_alert};
          vtam_pkg::OFF_REC_SEL: prdata <= {30'h00000000, rec_sel_reg};
          vtam_pkg::OFF_REC_ALERTS: prdata <= {17'h00000, rec_alerts_reg[rec_sel_reg]};
          vtam_pkg::OFF_REC_STAMP: prdata <= rec_stamp_reg[rec_sel_reg];
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_en_reg <= 1'b0;
      cyc_en_reg <= 1'b0;
      dev_en_reg <= 1'b1;
      has_en_reg <= 1'b1;
      full_en_reg <= 1'b0;
      grp_en_reg <= vtam_pkg::GRP_EN_DEF;
      stat_en_reg <= vtam_pkg::STAT_EN_DEF;
      acc_pt_reg <= 32'h0000_0000;
      cyc_pt_reg <= 32'h0000_0000;
      cyc_db_reg <= 16'h0000;
      acc_db_reg <= 16'h0000;
      dev_time_reg <= vtam_pkg::DEV_TIME_DEF_S;
      pst_lim_reg <= 16'h0000;
      integ_lim_reg <= vtam_pkg::TRAVEL_FULL;
      dz_reg <= vtam_pkg::DZ_DEF;
      rep_en_reg <= vtam_pkg::REP_EN_DEF;
      rec_sel_reg <= 2'h0;
    end else if (wr_en) begin
      unique case (paddr)
        vtam_pkg::OFF_CTRL: begin
          acc_en_reg <= pwdata[vtam_pkg::CTRL_ACC_EN];
          cyc_en_reg <= pwdata[vtam_pkg::CTRL_CYC_EN];
          dev_en_reg <= pwdata[vtam_pkg::CTRL_DEV_EN];
          has_en_reg <= pwdata[vtam_pkg::CTRL_HAS_EN];
          full_en_reg <= pwdata[vtam_pkg::CTRL_FULL_EN];
          grp_en_reg <= pwdata[vtam_pkg::CTRL_GRP_LSB +: 3];
          stat_en_reg <= pwdata[vtam_pkg::CTRL_STAT_LSB +: 9];
        end
        vtam_pkg::OFF_ACC_PT: acc_pt_reg <= pwdata;
        vtam_pkg::OFF_CYC_PT: cyc_pt_reg <= pwdata;
        vtam_pkg::OFF_DB: begin
          cyc_db_reg <= pwdata[15:0];
          acc_db_reg <= pwdata[vtam_pkg::HI_LSB +: 16];
        end
        vtam_pkg::OFF_DEV_TIME: dev_time_reg <= pwdata[15:0];
        vtam_pkg::OFF_PST_LIM: pst_lim_reg <= pwdata[15:0];
        vtam_pkg::OFF_INTEG: begin
          // Out-of-range settings saturate rather than being refused
          integ_lim_reg <= (pwdata[15:0] > vtam_pkg::TRAVEL_FULL) ?
            vtam_pkg::TRAVEL_FULL : pwdata[15:0];
          dz_reg <= (pwdata[vtam_pkg::HI_LSB +: 16] > vtam_pkg::DZ_MAX) ?
            vtam_pkg::DZ_MAX : pwdata[vtam_pkg::HI_LSB +: 16];
        end
        vtam_pkg::OFF_REP_EN: rep_en_reg <= pwdata[14:0];
        vtam_pkg::OFF_REC_SEL: rec_sel_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Completion of setup outranks a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_pt_reg <= vtam_pkg::DEV_POINT_DEF;
    end else if (setup_done) begin
      dev_pt_reg <= vtam_pkg::DEV_POINT_DEF;
    end else if (wr_en && hit(paddr, vtam_pkg::OFF_DEV_PT)) begin
      dev_pt_reg <= pwdata[15:0];
    end
  end

  // ==========================================
  // Travel accumulator
  assign acc_step = absdiff(travel, acc_ref_reg);
  assign acc_sum = {1'b0, acc_reg} + {17'h00000, acc_step};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 32'h0000_0000;
      acc_ref_reg <= 16'h0000;
    end else if (wr_acc) begin
      acc_reg <= pwdata;
      acc_ref_reg <= travel;
    end else if (acc_step > acc_db_reg) begin
      acc_reg <= acc_sum[32] ? 32'hFFFF_FFFF : acc_sum[31:0];
      acc_ref_reg <= travel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_alert <= 1'b0;
    end else if (wr_acc && pwdata < acc_pt_reg) begin
      acc_alert <= 1'b0;
    end else if (acc_en_reg && acc_reg > acc_pt_reg) begin
      acc_alert <= 1'b1;
    end
  end

  // ==========================================
  // Cycle counter
  assign cyc_up = {1'b0, travel} > {1'b0, cyc_ref_reg} + {1'b0, cyc_db_reg};
  assign cyc_dn = {1'b0, travel} + {1'b0, cyc_db_reg} < {1'b0, cyc_ref_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_reg <= 32'h0000_0000;
      cyc_ref_reg <= 16'h0000;
      dir_reg <= vtam_pkg::DIR_NONE;
    end else if (wr_cyc) begin
      cyc_reg <= pwdata;
      cyc_ref_reg <= travel;
    end else if (cyc_up || cyc_dn) begin
      // Reference follows travel so the window moves with each step past the deadband, counted or not
      cyc_ref_reg <= travel;
      dir_reg <= cyc_up ? vtam_pkg::DIR_UP : vtam_pkg::DIR_DOWN;
      unique case (dir_reg)
        vtam_pkg::DIR_UP: if (cyc_dn && cyc_reg != 32'hFFFF_FFFF) cyc_reg <= cyc_reg + 32'h1;
        vtam_pkg::DIR_DOWN: if (cyc_up && cyc_reg != 32'hFFFF_FFFF) cyc_reg <= cyc_reg + 32'h1;
        vtam_pkg::DIR_NONE: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_alert <= 1'b0;
    end else if (wr_cyc && pwdata < cyc_pt_reg) begin
      cyc_alert <= 1'b0;
    end else if (cyc_en_reg && cyc_reg > cyc_pt_reg) begin
      cyc_alert <= 1'b1;
    end
  end

  // ==========================================
  // Pressure deviation and partial stroke test
  assign dev_over = absdiff(press_target, press_actual) > dev_pt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1));
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 :
        tick_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_cnt_reg <= 16'h0000;
      dev_alert <= 1'b0;
    end else if (!dev_en_reg || !dev_over) begin
      dev_cnt_reg <= 16'h0000;
      dev_alert <= 1'b0;
    end else begin
      if (tick_reg && dev_cnt_reg != 16'hFFFF) dev_cnt_reg <= dev_cnt_reg + 16'h1;
      dev_alert <= dev_cnt_reg > dev_time_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partial_stroke_test_stop <= 1'b0;
    end else begin
      partial_stroke_test_stop <= partial_stroke_test_active && (partial_stroke_test_vent ?
        press_actual <= pst_lim_reg : press_actual >= pst_lim_reg);
    end
  end

  // ==========================================
  // Integrator clamp and dead zone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_out <= 16'h0000;
      integ_hold <= 1'b0;
    end else begin
      integ_out <= (integ_in > integ_lim_reg) ? integ_lim_reg : integ_in;
      integ_hold <= absdiff(travel, setpoint) <= dz_reg;
    end
  end

  // ==========================================
  // Alert record
  assign elig = alerts_in & rep_en_reg & {grp_en_reg[2], {8{grp_en_reg[1]}},
    {6{grp_en_reg[0]}}};
  assign rec_trig = |(elig & ~elig_prev_reg);
  assign rec_clr = wr_en && hit(paddr, vtam_pkg::OFF_REC_CLEAR) && pwdata[0] && elig == 15'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elig_prev_reg <= 15'h0000;
      rec_cnt_reg <= 3'h0;
    end else begin
      elig_prev_reg <= elig;
      if (rec_clr) begin
        rec_cnt_reg <= 3'h0;
      end else if (rec_trig && rec_cnt_reg != 3'(vtam_pkg::REC_DEPTH)) begin
        rec_cnt_reg <= rec_cnt_reg + 3'h1;
      end
    end
  end

  // Full record drops new entries so the oldest history survives
  for (genvar i = 0; i < vtam_pkg::REC_DEPTH; i++) begin : g_rec
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rec_alerts_reg[i] <= 15'h0000;
        rec_stamp_reg[i] <= '0;
      end else if (rec_trig && rec_cnt_reg == 3'(i)) begin
        rec_alerts_reg[i] <= elig;
        rec_stamp_reg[i] <= rtc_now;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_has_entries <= 1'b0;
      rec_full <= 1'b0;
      status_out <= 9'h000;
    end else begin
      rec_has_entries <= has_en_reg && rec_cnt_reg != 3'h0;
      rec_full <= full_en_reg && rec_cnt_reg == 3'(vtam_pkg::REC_DEPTH);
      status_out <= status_in & stat_en_reg;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_acc_alert_set: assert property (acc_en_reg && acc_reg > acc_pt_reg && !wr_acc |=> acc_alert)
    else $error("accumulator alert missed");
  a_acc_alert_hold: assert property (acc_alert && !wr_acc |=> acc_alert)
    else $error("accumulator alert dropped");
  a_cyc_alert_hold: assert property (cyc_alert && !wr_cyc |=> cyc_alert)
    else $error("cycle alert dropped");
  a_acc_sat_top: assert property (acc_reg == 32'hFFFF_FFFF && !wr_acc |=> acc_reg == 32'hFFFF_FFFF)
    else $error("accumulator wrapped");
  a_dev_alert_drop: assert property (!dev_over |=> !dev_alert)
    else $error("deviation alert held");
  a_dev_alert_rise: assert property ($rose(dev_alert) |-> $past(dev_cnt_reg > dev_time_reg && dev_over))
    else $error("deviation alert early");
  a_dev_timer_restart: assert property (dev_en_reg && !dev_over |=> dev_cnt_reg == 16'h0000)
    else $error("deviation timer kept");
  a_pst_vent_stop: assert property (partial_stroke_test_active && partial_stroke_test_vent &&
    press_actual <= pst_lim_reg |=> partial_stroke_test_stop)
    else $error("stroke test not stopped");
  a_integ_clamp: assert property (##1 integ_out <= $past(integ_lim_reg))
    else $error("integrator over limit");
  a_rec_clear_guard: assert property ($fell(rec_cnt_reg != 3'h0) |-> $past(elig == 15'h0000))
    else $error("record cleared with active alert");
  a_rec_store: assert property (rec_trig && rec_cnt_reg == 3'h0 |=> rec_alerts_reg[0] == $past(elig))
    else $error("record entry wrong");
endmodule
`default_nettype wire

// ==== shared/vtam_pkg.sv ====
// Constants and carriers for the valve travel and alert monitor.
// Assumes travel in 0.01 % steps and pressure in 0.01 psi steps.
`default_nettype none
package vtam_pkg;
  // ==========================================
  // Bus map (byte offsets)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_ACC_PT = 8'h08;
  localparam logic [7:0] OFF_CYC = 8'h0C;
  localparam logic [7:0] OFF_CYC_PT = 8'h10;
  localparam logic [7:0] OFF_DB = 8'h14;
  localparam logic [7:0] OFF_DEV_PT = 8'h18;
  localparam logic [7:0] OFF_DEV_TIME = 8'h1C;
  localparam logic [7:0] OFF_PST_LIM = 8'h20;
  localparam logic [7:0] OFF_INTEG = 8'h24;
  localparam logic [7:0] OFF_REP_EN = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;
  localparam logic [7:0] OFF_REC_SEL = 8'h30;
  localparam logic [7:0] OFF_REC_ALERTS = 8'h34;
  localparam logic [7:0] OFF_REC_STAMP = 8'h38;
  localparam logic [7:0] OFF_REC_CLEAR = 8'h3C;
  // ==========================================
  // Control word, status word and upper-half field positions
  localparam int CTRL_ACC_EN = 0;
  localparam int CTRL_CYC_EN = 1;
  localparam int CTRL_DEV_EN = 2;
  localparam int CTRL_HAS_EN = 3;
  localparam int CTRL_FULL_EN = 4;
  localparam int CTRL_GRP_LSB = 8;
  localparam int CTRL_STAT_LSB = 16;
  localparam int HI_LSB = 16;
  localparam int STS_CNT_LSB = 8;
  // ==========================================
  // Reset values and limits
  localparam logic [2:0] GRP_EN_DEF = 3'h3;
  localparam logic [8:0] STAT_EN_DEF = 9'h1B1;
  localparam logic [14:0] REP_EN_DEF = 15'h7FFF;
  localparam logic [15:0] TRAVEL_FULL = 16'h2710;
  localparam logic [15:0] DZ_MAX = 16'h00C8;
  localparam logic [15:0] DZ_DEF = 16'h0019;
  localparam int DEV_POINT_PSI = 2;
  localparam int PRESS_STEPS_PER_PSI = 100;
  localparam logic [15:0] DEV_POINT_DEF = 16'(DEV_POINT_PSI * PRESS_STEPS_PER_PSI);
  localparam logic [15:0] DEV_TIME_DEF_S = 16'h001E;
  // ==========================================
  // Timing and record depth
  localparam int CLK_HZ = 20000000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYCLES = CLK_HZ * SECOND_S;
  localparam int REC_DEPTH = 4;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic [5:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } vtam_rtc_s;
  typedef struct packed {
    logic misc;
    logic [7:0] fail;
    logic [5:0] valve;
  } vtam_alerts_s;
  typedef enum {DIR_NONE, DIR_UP, DIR_DOWN} vtam_dir_e;
endpackage
`default_nettype wire

// ==== tb/vtam_sense_model.sv ====
// Sensor side model: travel, pressures and instrument clock.
// Assumes the bench sets wanted values; they appear one pclk later.
`default_nettype none
module vtam_sense_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] travel_set,
  input wire logic [15:0] press_t_set,
  input wire logic [15:0] press_a_set,
  input wire vtam_pkg::vtam_rtc_s rtc_set,
  output logic [15:0] travel,
  output logic [15:0] press_target,
  output logic [15:0] press_actual,
  output vtam_pkg::vtam_rtc_s rtc_now
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Measurements, registered like a real sampler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      travel <= 16'h0000;
      press_target <= 16'h0000;
      press_actual <= 16'h0000;
    end else begin
      travel <= travel_set;
      press_target <= press_t_set;
      press_actual <= press_a_set;
    end
  end
  // ==========================================
  // Clock; an illegal hour is never shown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_now <= '0;
    end else begin
      rtc_now <= (rtc_set.hour > 5'h17) ? '0 : rtc_set;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the travel and alert monitor.
// Assumes the package and the sensor model are compiled first.
`default_nettype none
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (x)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short second keeps deviation tests brief
  localparam int TICK = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] trav_set = 16'h0000, pt_set = 16'h0000, pa_set = 16'h0000;
  logic [15:0] travel, press_target, press_actual, integ_out;
  logic [15:0] setpoint = 16'h0000, integ_in = 16'h0000;
  logic pst_act = 1'b0, pst_vent = 1'b0, setup_done = 1'b0;
  vtam_pkg::vtam_alerts_s alerts_in = '0;
  vtam_pkg::vtam_rtc_s rtc_set = '{6'h19, 4'hC, 5'h1F, 5'h17, 6'h3B, 6'h3A};
  vtam_pkg::vtam_rtc_s rtc_now;
  logic [8:0] status_in = 9'h1FF, status_out;
  logic pst_stop, dev_alert, acc_alert, cyc_alert, integ_hold, rec_has, rec_full;
  int miscompares = 0;
  int checks_done = 0;
  always #25 pclk = ~pclk;
  vtam_sense_model u_sense (.pclk(pclk), .presetn(presetn), .travel_set(trav_set),
    .press_t_set(pt_set), .press_a_set(pa_set), .rtc_set(rtc_set), .travel(travel),
    .press_target(press_target), .press_actual(press_actual), .rtc_now(rtc_now));
  vtam_monitor #(.TICK_CYCLES(TICK)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .travel(travel), .setpoint(setpoint),
    .press_target(press_target), .press_actual(press_actual),
    .partial_stroke_test_active(pst_act), .partial_stroke_test_vent(pst_vent),
    .setup_done(setup_done), .integ_in(integ_in), .alerts_in(alerts_in),
    .rtc_now(rtc_now), .status_in(status_in), .partial_stroke_test_stop(pst_stop),
    .dev_alert(dev_alert), .acc_alert(acc_alert), .cyc_alert(cyc_alert),
    .integ_out(integ_out), .integ_hold(integ_hold), .rec_has_entries(rec_has),
    .rec_full(rec_full), .status_out(status_out));
  // ==========================================
  // Bus and drive helpers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Checks land on the falling edge, after the design's updates
  task automatic gap(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic mv(input logic [15:0] v);
    @(posedge pclk) trav_set <= v;
    gap(3);
  endtask
  task automatic prs(input logic [15:0] t, input logic [15:0] a);
    @(posedge pclk);
    pt_set <= t;
    pa_set <= a;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_defaults();
    rd(vtam_pkg::OFF_CTRL);
    `CHK(q, 32'h01B1030C)
    rd(vtam_pkg::OFF_DEV_TIME);
    `CHK(q, 32'h0000001E)
    rd(vtam_pkg::OFF_INTEG);
    `CHK(q, 32'h00192710)
    rd(8'h40);
    `CHK({e, q}, 33'h100000000)
    gap(1);
    `CHK(status_out, 9'h1B1)
  endtask
  task automatic t_accum();
    wr(vtam_pkg::OFF_DB, 32'h00640064);
    wr(vtam_pkg::OFF_ACC, 32'h0);
    mv(16'h0032);
    mv(16'h0000);
    mv(16'h00C8);
    rd(vtam_pkg::OFF_ACC);
    `CHK(q, 32'h000000C8)
    wr(vtam_pkg::OFF_ACC_PT, 32'h64);
    gap(2);
    `CHK(acc_alert, 1'b0)
    wr(vtam_pkg::OFF_CTRL, 32'h01B1030D);
    gap(2);
    `CHK(acc_alert, 1'b1)
    wr(vtam_pkg::OFF_ACC, 32'h0);
    gap(2);
    `CHK(acc_alert, 1'b0)
    rd(vtam_pkg::OFF_ACC);
    `CHK(q, 32'h0)
    wr(vtam_pkg::OFF_ACC, 32'hFFFFFFF0);
    mv(16'h0190);
    rd(vtam_pkg::OFF_ACC);
    `CHK(q, 32'hFFFFFFFF)
  endtask
  task automatic t_cycle();
    wr(vtam_pkg::OFF_CYC, 32'h0);
    mv(16'h00C8);
    mv(16'h00FA);
    mv(16'h00C8);
    mv(16'h0190);
    rd(vtam_pkg::OFF_CYC);
    `CHK(q, 32'h2)
    wr(vtam_pkg::OFF_CYC_PT, 32'h1);
    wr(vtam_pkg::OFF_CTRL, 32'h01B1030F);
    gap(2);
    `CHK(cyc_alert, 1'b1)
    wr(vtam_pkg::OFF_CYC, 32'h0);
    gap(2);
    `CHK(cyc_alert, 1'b0)
  endtask
  task automatic t_dev();
    int n;
    wr(vtam_pkg::OFF_DEV_PT, 32'h1F4);
    @(posedge pclk) setup_done <= 1'b1;
    @(posedge pclk) setup_done <= 1'b0;
    rd(vtam_pkg::OFF_DEV_PT);
    `CHK(q, 32'h000000C8)
    wr(vtam_pkg::OFF_DEV_TIME, 32'h2);
    prs(16'h03E8, 16'h0514);
    gap(5);
    `CHK(dev_alert, 1'b0)
    prs(16'h03E8, 16'h03E8);
    gap(1);
    prs(16'h03E8, 16'h0514);
    gap(5);
    `CHK(dev_alert, 1'b0)
    n = 0;
    while (dev_alert !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    `CHK(dev_alert, 1'b1)
    prs(16'h03E8, 16'h04B0);
    gap(3);
    `CHK(dev_alert, 1'b0)
  endtask
  task automatic t_pst();
    wr(vtam_pkg::OFF_PST_LIM, 32'h3E8);
    @(posedge pclk);
    pst_act <= 1'b1;
    pst_vent <= 1'b1;
    prs(16'h03E8, 16'h05DC);
    gap(3);
    `CHK(pst_stop, 1'b0)
    prs(16'h03E8, 16'h0384);
    gap(3);
    `CHK(pst_stop, 1'b1)
    @(posedge pclk) pst_act <= 1'b0;
    @(posedge pclk) pst_vent <= 1'b0;
    @(posedge pclk) pst_act <= 1'b1;
    gap(3);
    `CHK(pst_stop, 1'b0)
    prs(16'h03E8, 16'h044C);
    gap(3);
    `CHK(pst_stop, 1'b1)
  endtask
  task automatic t_record();
    @(posedge pclk) alerts_in <= 15'h4000;
    gap(3);
    `CHK(rec_has, 1'b0)
    @(posedge pclk) alerts_in <= 15'h4041;
    gap(3);
    `CHK(rec_has, 1'b1)
    wr(vtam_pkg::OFF_REC_SEL, 32'h0);
    rd(vtam_pkg::OFF_REC_ALERTS);
    `CHK(q, 32'h00000041)
    rd(vtam_pkg::OFF_REC_STAMP);
    `CHK(q, 32'(rtc_set))
    wr(vtam_pkg::OFF_REC_CLEAR, 32'h1);
    rd(vtam_pkg::OFF_STATUS);
    `CHK(q[10:8], 3'h1)
    // Misc alert stays up, but its group is off
    @(posedge pclk) alerts_in <= 15'h4000;
    wr(vtam_pkg::OFF_REC_CLEAR, 32'h1);
    gap(1);
    `CHK(rec_has, 1'b0)
    wr(vtam_pkg::OFF_CTRL, 32'h01B1031F);
    repeat (4) begin
      @(posedge pclk) alerts_in <= 15'h0001;
      gap(2);
      @(posedge pclk) alerts_in <= 15'h0000;
      gap(2);
    end
    `CHK(rec_full, 1'b1)
    rd(vtam_pkg::OFF_STATUS);
    `CHK(q[10:8], 3'h4)
  endtask
  task automatic t_integ();
    wr(vtam_pkg::OFF_INTEG, 32'h00321388);
    @(posedge pclk);
    integ_in <= 16'h1770;
    setpoint <= 16'h03E8;
    gap(2);
    `CHK(integ_out, 16'h1388)
    @(posedge pclk) integ_in <= 16'h0BB8;
    gap(2);
    `CHK(integ_out, 16'h0BB8)
    mv(16'h041A);
    `CHK(integ_hold, 1'b1)
    mv(16'h041B);
    `CHK(integ_hold, 1'b0)
    wr(vtam_pkg::OFF_INTEG, 32'h00FF3000);
    rd(vtam_pkg::OFF_INTEG);
    `CHK(q, 32'h00C82710)
  endtask
  // ==========================================
  // Sequence, watchdog and verdict
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_accum();
    t_cycle();
    t_dev();
    t_pst();
    t_record();
    t_integ();
    print_verdict();
  end
  // Whole run needs well under a tenth of this
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
